// >>> rtl/dcl_defines.svh
`ifndef DCL_DEFINES_SVH
`define DCL_DEFINES_SVH

// clock and timing
`define DCL_CLK_MHZ 200
`define DCL_SETTLE_NS 1000
`define DCL_SETTLE_CYC ((`DCL_SETTLE_NS * `DCL_CLK_MHZ + 999) / 1000)
`define DCL_RST_HOLD_NS 100
`define DCL_RST_HOLD_CYC ((`DCL_RST_HOLD_NS * `DCL_CLK_MHZ + 999) / 1000)

// device register offsets
`define DCL_DEV_CALIB 8'h00
`define DCL_DEV_PHY 8'h04
`define DCL_DEV_PRIO 8'h08
`define DCL_DEV_REFR 8'h0c
`define DCL_DEV_STAT 8'h10

// impedance_calib_ctrl fields
`define DCL_CAL_REL 0
`define DCL_CAL_LOCK 1
`define DCL_CAL_IOPD 2
`define DCL_CAL_PD 3
`define DCL_CAL_READY 4

// phy_ctrl_one fields
`define DCL_PHY_LAT_W 4
`define DCL_PHY_STRB 6
`define DCL_PHY_PDEN 7

// burst_priority_reg reset value
`define DCL_PRIO_RESET 8'h7f

// refresh_ctrl_reg fields
`define DCL_REF_RR_W 16
`define DCL_REF_MCS 23
`define DCL_REF_SEL 30
`define DCL_REF_LP 31

// sdram_status_reg fields
`define DCL_STAT_PHY_READY 2

// own software registers
`define DCL_SW_CMD 4'h0
`define DCL_SW_CFG 4'h4
`define DCL_SW_STAT 4'h8
`define DCL_CMD_BOOT 0
`define DCL_CMD_SLEEP 1
`define DCL_CMD_WAKE 2
`define DCL_CFG_LAT_LSB 16
`define DCL_CFG_PRIO_LSB 20
`define DCL_CFG_KEEP_SRC 28

`endif

// >>> rtl/dcl_pkg.sv
package dcl_pkg;
    typedef logic [7:0] dcl_daddr_t;
    typedef logic [31:0] dcl_word_t;
    typedef logic [3:0] dcl_saddr_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h00,
        ST_BOOT_CLK = 5'h01,
        ST_CAL_CLR = 5'h03,
        ST_CAL_WAIT = 5'h02,
        ST_CAL_REL = 5'h06,
        ST_CAL_POLL = 5'h07,
        ST_CAL_LOCK = 5'h05,
        ST_CAL_PD = 5'h04,
        ST_PHY = 5'h0c,
        ST_PRIO = 5'h0d,
        ST_MRST = 5'h0f,
        ST_READY = 5'h0e,
        ST_SR_EN = 5'h0a,
        ST_MCS_EN = 5'h0b,
        ST_PHY_POLL = 5'h09,
        ST_GATE_BUS = 5'h08,
        ST_GATE_SRC = 5'h18,
        ST_ASLEEP = 5'h19,
        ST_UNG_SRC = 5'h1b,
        ST_UNG_BUS = 5'h1a,
        ST_CLR_MCS = 5'h1e,
        ST_CLR_LP = 5'h1f
    } dcl_state_e;
endpackage : dcl_pkg

// >>> rtl/dcl_acc_if.sv
`timescale 1ns/10ps
interface dcl_acc_if;
    import dcl_pkg::*;
    logic req;
    logic wr;
    dcl_daddr_t addr;
    dcl_word_t wdata;
    logic done;
    dcl_word_t rdata;
    modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : dcl_acc_if

// >>> rtl/dcl_acc_engine.sv
`timescale 1ns/10ps
`include "dcl_defines.svh"
// one device register access per request; read data sampled the cycle after the strobe
module dcl_acc_engine (
    input wire logic clk,
    input wire logic rst,
    dcl_acc_if.eng acc,
    output dcl_pkg::dcl_daddr_t dev_addr,
    output dcl_pkg::dcl_word_t dev_wdata,
    output logic dev_wr,
    output logic dev_rd,
    input wire dcl_pkg::dcl_word_t dev_rdata
);
    import dcl_pkg::*;

    dcl_daddr_t addr_r, addr_nxt;
    dcl_word_t wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic wr_r, wr_nxt, rd_r, rd_nxt, rd_d_r, rd_d_nxt, done_r, done_nxt;

    always_comb begin
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        rd_d_nxt = rd_r;
        done_nxt = 1'b0;
        if (acc.req) begin
            addr_nxt = acc.addr;
            wdata_nxt = acc.wr ? acc.wdata : 32'h0;
            wr_nxt = acc.wr;
            rd_nxt = !acc.wr;
        end
        if (wr_r) begin
            done_nxt = 1'b1;
        end
        if (rd_d_r) begin
            done_nxt = 1'b1;
            rdata_nxt = dev_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= 8'h00;
            wdata_r <= 32'h0;
            rdata_r <= 32'h0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            rd_d_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            rd_d_r <= rd_d_nxt;
            done_r <= done_nxt;
        end
    end

    assign dev_addr = addr_r;
    assign dev_wdata = wdata_r;
    assign dev_wr = wr_r;
    assign dev_rd = rd_r;
    assign acc.done = done_r;
    assign acc.rdata = rdata_r;
endmodule : dcl_acc_engine

// >>> rtl/dcl_host_ctrl.sv
`timescale 1ns/10ps
`include "dcl_defines.svh"
// Functional notes
// - clear release, lock and both power-downs, wait a reference period, then release
// - poll the calibration ready flag until high before going on
// - after ready, set lock, then both power-down bits; impedance stays fixed
// - one phy control write sets strobe gating, phy power-down enable, read latency
// - burst priority register must be written with a non-default value
// - finish bring-up with a module reset and clocks re-enabled
// - module reset with calibration clock off breaks accesses; keep that clock on
// - bus and source clocks gated only in self-refresh, never power-down; the bus clock is also gated during the module reset
// - sdram in self-refresh before gating; keep source clock if memory needs it
// - after phy ready low, gate bus clock first, then source clocks
// - restore: source clock, bus clock, clear clock-stop, then clear low-power
// - no register or data access before calibration completes
module dcl_host_ctrl #(
    parameter logic [15:0] SETTLE_CYC = 16'(`DCL_SETTLE_CYC),
    parameter logic [15:0] RST_HOLD_CYC = 16'(`DCL_RST_HOLD_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire dcl_pkg::dcl_saddr_t sw_addr,
    input wire dcl_pkg::dcl_word_t sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output dcl_pkg::dcl_word_t sw_rdata,
    input wire logic ref_clk,
    output dcl_pkg::dcl_daddr_t dev_addr,
    output dcl_pkg::dcl_word_t dev_wdata,
    output logic dev_wr,
    output logic dev_rd,
    input wire dcl_pkg::dcl_word_t dev_rdata,
    output logic bus_clk_en,
    output logic src_clk_en,
    output logic calib_clk_en,
    output logic mod_rst
);
    import dcl_pkg::*;

    if (SETTLE_CYC < 16'h1 || RST_HOLD_CYC < 16'h1) begin : g_bad_param
        $error("dcl_host_ctrl: wait counts must be at least one cycle");
    end

    function automatic dcl_word_t calib_word(input logic rel, input logic lock, input logic pd);
        calib_word = 32'h0;
        calib_word[`DCL_CAL_REL] = rel;
        calib_word[`DCL_CAL_LOCK] = lock;
        calib_word[`DCL_CAL_IOPD] = pd;
        calib_word[`DCL_CAL_PD] = pd;
    endfunction : calib_word

    function automatic dcl_word_t refr_word(input logic lp, input logic mcs,
                                            input logic [15:0] rr);
        refr_word = 32'h0;
        refr_word[`DCL_REF_RR_W-1:0] = rr;
        refr_word[`DCL_REF_MCS] = mcs;
        refr_word[`DCL_REF_SEL] = 1'b0;
        refr_word[`DCL_REF_LP] = lp;
    endfunction : refr_word

    dcl_acc_if acc ();

    dcl_acc_engine u_eng (
        .clk(clk),
        .rst(rst),
        .acc(acc),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_wr(dev_wr),
        .dev_rd(dev_rd),
        .dev_rdata(dev_rdata)
    );

    // reference clock sampled into this domain
    logic ref_s1_r, ref_s2_r, ref_s3_r, ref_rise;
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
        end else begin
            ref_s1_r <= ref_clk;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
        end
    end
    assign ref_rise = ref_s2_r && !ref_s3_r;

    dcl_state_e st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic pend_r, pend_nxt, req_r, req_nxt, awr_r, awr_nxt;
    dcl_daddr_t aaddr_r, aaddr_nxt;
    dcl_word_t awdata_r, awdata_nxt, cfg_r, cfg_nxt, sw_rdata_r, sw_rdata_nxt;
    logic bus_r, bus_nxt, src_r, src_nxt, cal_r, cal_nxt, mrst_r, mrst_nxt;
    logic calibrated_r, calibrated_nxt, cfgerr_r, cfgerr_nxt;
    logic step, do_acc, d_wr, cmd_boot, cmd_sleep, cmd_wake, busy;
    dcl_daddr_t d_addr;
    dcl_word_t d_data;

    assign acc.req = req_r;
    assign acc.wr = awr_r;
    assign acc.addr = aaddr_r;
    assign acc.wdata = awdata_r;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        req_nxt = 1'b0;
        awr_nxt = awr_r;
        aaddr_nxt = aaddr_r;
        awdata_nxt = awdata_r;
        bus_nxt = bus_r;
        src_nxt = src_r;
        cal_nxt = cal_r;
        mrst_nxt = mrst_r;
        calibrated_nxt = calibrated_r;
        cfgerr_nxt = cfgerr_r;
        cfg_nxt = cfg_r;
        do_acc = 1'b0;
        d_wr = 1'b1;
        d_addr = `DCL_DEV_CALIB;
        d_data = 32'h0;
        step = pend_r && acc.done;
        cmd_boot = sw_wr && sw_addr == `DCL_SW_CMD && sw_wdata[`DCL_CMD_BOOT];
        cmd_sleep = sw_wr && sw_addr == `DCL_SW_CMD && sw_wdata[`DCL_CMD_SLEEP];
        cmd_wake = sw_wr && sw_addr == `DCL_SW_CMD && sw_wdata[`DCL_CMD_WAKE];
        if (sw_wr && sw_addr == `DCL_SW_CFG) begin
            cfg_nxt = sw_wdata;
        end
        unique case (st_r)
            ST_IDLE: begin
                if (cmd_boot) begin
                    if (cfg_r[`DCL_CFG_PRIO_LSB +: 8] == `DCL_PRIO_RESET) begin
                        cfgerr_nxt = 1'b1;
                    end else begin
                        cfgerr_nxt = 1'b0;
                        src_nxt = 1'b1;
                        cal_nxt = 1'b1;
                        cnt_nxt = 16'h0;
                        st_nxt = ST_BOOT_CLK;
                    end
                end
            end
            ST_BOOT_CLK, ST_UNG_SRC: begin
                if (cnt_r == SETTLE_CYC - 16'h1) begin
                    bus_nxt = 1'b1;
                    st_nxt = (st_r == ST_BOOT_CLK) ? ST_CAL_CLR : ST_UNG_BUS;
                end else begin
                    cnt_nxt = cnt_r + 16'h1;
                end
            end
            ST_CAL_CLR: begin
                do_acc = 1'b1;
                d_data = calib_word(1'b0, 1'b0, 1'b0);
                if (step) begin
                    cnt_nxt = 16'h0;
                    st_nxt = ST_CAL_WAIT;
                end
            end
            ST_CAL_WAIT: begin
                // two sampled rising edges span at least one full reference period
                if (ref_rise) begin
                    if (cnt_r == 16'h1) begin
                        st_nxt = ST_CAL_REL;
                    end else begin
                        cnt_nxt = cnt_r + 16'h1;
                    end
                end
            end
            ST_CAL_REL: begin
                do_acc = 1'b1;
                d_data = calib_word(1'b1, 1'b0, 1'b0);
                if (step) st_nxt = ST_CAL_POLL;
            end
            ST_CAL_POLL: begin
                do_acc = 1'b1;
                d_wr = 1'b0;
                if (step && acc.rdata[`DCL_CAL_READY]) st_nxt = ST_CAL_LOCK;
            end
            ST_CAL_LOCK: begin
                do_acc = 1'b1;
                d_data = calib_word(1'b1, 1'b1, 1'b0);
                if (step) st_nxt = ST_CAL_PD;
            end
            ST_CAL_PD: begin
                do_acc = 1'b1;
                d_data = calib_word(1'b1, 1'b1, 1'b1);
                if (step) begin
                    calibrated_nxt = 1'b1;
                    st_nxt = ST_PHY;
                end
            end
            ST_PHY: begin
                do_acc = 1'b1;
                d_addr = `DCL_DEV_PHY;
                d_data[`DCL_PHY_LAT_W-1:0] = cfg_r[`DCL_CFG_LAT_LSB +: `DCL_PHY_LAT_W];
                d_data[`DCL_PHY_STRB] = 1'b1;
                d_data[`DCL_PHY_PDEN] = 1'b1;
                if (step) st_nxt = ST_PRIO;
            end
            ST_PRIO: begin
                do_acc = 1'b1;
                d_addr = `DCL_DEV_PRIO;
                d_data[7:0] = cfg_r[`DCL_CFG_PRIO_LSB +: 8];
                if (step) begin
                    cnt_nxt = 16'h0;
                    bus_nxt = 1'b0;
                    mrst_nxt = 1'b1;
                    st_nxt = ST_MRST;
                end
            end
            ST_MRST: begin
                if (cnt_r == RST_HOLD_CYC - 16'h1) begin
                    mrst_nxt = 1'b0;
                    bus_nxt = 1'b1;
                    st_nxt = ST_READY;
                end else begin
                    cnt_nxt = cnt_r + 16'h1;
                end
            end
            ST_READY: begin
                if (cmd_sleep) st_nxt = ST_SR_EN;
            end
            ST_SR_EN: begin
                do_acc = 1'b1;
                d_addr = `DCL_DEV_REFR;
                d_data = refr_word(1'b1, 1'b0, cfg_r[15:0]);
                if (step) st_nxt = ST_MCS_EN;
            end
            ST_MCS_EN: begin
                do_acc = 1'b1;
                d_addr = `DCL_DEV_REFR;
                d_data = refr_word(1'b1, 1'b1, cfg_r[15:0]);
                if (step) st_nxt = ST_PHY_POLL;
            end
            ST_PHY_POLL: begin
                do_acc = 1'b1;
                d_wr = 1'b0;
                d_addr = `DCL_DEV_STAT;
                if (step && !acc.rdata[`DCL_STAT_PHY_READY]) st_nxt = ST_GATE_BUS;
            end
            ST_GATE_BUS: begin
                bus_nxt = 1'b0;
                st_nxt = ST_GATE_SRC;
            end
            ST_GATE_SRC: begin
                if (!cfg_r[`DCL_CFG_KEEP_SRC]) begin
                    src_nxt = 1'b0;
                    cal_nxt = 1'b0;
                end
                st_nxt = ST_ASLEEP;
            end
            ST_ASLEEP: begin
                if (cmd_wake) begin
                    src_nxt = 1'b1;
                    cal_nxt = 1'b1;
                    cnt_nxt = 16'h0;
                    st_nxt = ST_UNG_SRC;
                end
            end
            ST_UNG_BUS: st_nxt = ST_CLR_MCS;
            ST_CLR_MCS: begin
                do_acc = 1'b1;
                d_addr = `DCL_DEV_REFR;
                d_data = refr_word(1'b1, 1'b0, cfg_r[15:0]);
                if (step) st_nxt = ST_CLR_LP;
            end
            ST_CLR_LP: begin
                do_acc = 1'b1;
                d_addr = `DCL_DEV_REFR;
                d_data = refr_word(1'b0, 1'b0, cfg_r[15:0]);
                if (step) st_nxt = ST_READY;
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (do_acc && !pend_r) begin
            req_nxt = 1'b1;
            pend_nxt = 1'b1;
            awr_nxt = d_wr;
            aaddr_nxt = d_addr;
            awdata_nxt = d_data;
        end
        if (step) pend_nxt = 1'b0;
    end

    assign busy = !(st_r == ST_IDLE || st_r == ST_READY || st_r == ST_ASLEEP);

    always_comb begin
        sw_rdata_nxt = 32'h0;
        if (sw_rd && sw_addr == `DCL_SW_CFG) sw_rdata_nxt = cfg_r;
        if (sw_rd && sw_addr == `DCL_SW_STAT) begin
            sw_rdata_nxt = {19'h0, st_r, 3'h0, cfgerr_r, st_r == ST_ASLEEP,
                            st_r == ST_READY, calibrated_r, busy};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= ST_IDLE;
            cnt_r <= 16'h0;
            pend_r <= 1'b0;
            req_r <= 1'b0;
            awr_r <= 1'b0;
            aaddr_r <= 8'h00;
            awdata_r <= 32'h0;
            bus_r <= 1'b0;
            src_r <= 1'b0;
            cal_r <= 1'b0;
            mrst_r <= 1'b0;
            calibrated_r <= 1'b0;
            cfgerr_r <= 1'b0;
            cfg_r <= 32'h0;
            sw_rdata_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            req_r <= req_nxt;
            awr_r <= awr_nxt;
            aaddr_r <= aaddr_nxt;
            awdata_r <= awdata_nxt;
            bus_r <= bus_nxt;
            src_r <= src_nxt;
            cal_r <= cal_nxt;
            mrst_r <= mrst_nxt;
            calibrated_r <= calibrated_nxt;
            cfgerr_r <= cfgerr_nxt;
            cfg_r <= cfg_nxt;
            sw_rdata_r <= sw_rdata_nxt;
        end
    end

    assign sw_rdata = sw_rdata_r;
    assign bus_clk_en = bus_r;
    assign src_clk_en = src_r;
    assign calib_clk_en = cal_r;
    assign mod_rst = mrst_r;

    // helpers watching the device port
    logic [1:0] rises_r;
    logic rd_cal_d_r, ready_seen_r, sr_on_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            rises_r <= 2'h0;
            rd_cal_d_r <= 1'b0;
            ready_seen_r <= 1'b0;
            sr_on_r <= 1'b0;
        end else begin
            rd_cal_d_r <= dev_rd && dev_addr == `DCL_DEV_CALIB;
            if (dev_wr && dev_addr == `DCL_DEV_CALIB && dev_wdata == 32'h0) begin
                rises_r <= 2'h0;
                ready_seen_r <= 1'b0;
            end else if (ref_rise && rises_r != 2'h3) begin
                rises_r <= rises_r + 2'h1;
            end
            if (rd_cal_d_r && dev_rdata[`DCL_CAL_READY]) ready_seen_r <= 1'b1;
            if (dev_wr && dev_addr == `DCL_DEV_REFR) begin
                sr_on_r <= dev_wdata[`DCL_REF_LP] && !dev_wdata[`DCL_REF_SEL];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_cal_ref_wait: assert property (dev_wr && dev_addr == `DCL_DEV_CALIB &&
        dev_wdata[`DCL_CAL_REL] && !dev_wdata[`DCL_CAL_LOCK] |-> rises_r >= 2'h2)
        else $error("calibration released before a reference period");
    chk_ready_before_lock: assert property (dev_wr && dev_addr == `DCL_DEV_CALIB &&
        dev_wdata[`DCL_CAL_LOCK] |-> ready_seen_r)
        else $error("lock written before ready was read high");
    chk_pd_after_lock: assert property (dev_wr && dev_addr == `DCL_DEV_CALIB &&
        dev_wdata[`DCL_CAL_IOPD] |-> dev_wdata[`DCL_CAL_LOCK] && dev_wdata[`DCL_CAL_PD]
        && $past(dev_wdata[`DCL_CAL_LOCK], 2))
        else $error("power-down set without lock first");
    chk_phy_word: assert property (dev_wr && dev_addr == `DCL_DEV_PHY |->
        dev_wdata[`DCL_PHY_STRB] && dev_wdata[`DCL_PHY_PDEN])
        else $error("phy control word incomplete");
    chk_prio_value: assert property (dev_wr && dev_addr == `DCL_DEV_PRIO |->
        dev_wdata[7:0] != `DCL_PRIO_RESET)
        else $error("burst priority left at default");
    chk_rst_release: assert property ($rose(mod_rst) |-> !bus_clk_en ##[1:1000]
        $fell(mod_rst) && bus_clk_en)
        else $error("module reset not released with clocks");
    chk_rst_calclk: assert property (mod_rst |-> calib_clk_en && calibrated_r)
        else $error("module reset while calibration clock off");
    chk_gate_selfref: assert property ($fell(bus_clk_en) && !mod_rst |-> sr_on_r)
        else $error("bus clock gated outside self-refresh");
    chk_src_order: assert property ($fell(src_clk_en) |-> !bus_clk_en && sr_on_r)
        else $error("source clock stopped before bus clock");
    chk_wake_order: assert property (dev_wr && dev_addr == `DCL_DEV_REFR &&
        !dev_wdata[`DCL_REF_LP] |-> !dev_wdata[`DCL_REF_MCS] && bus_clk_en && src_clk_en)
        else $error("low-power cleared out of order");
    chk_early_access: assert property ((dev_wr || dev_rd) &&
        dev_addr != `DCL_DEV_CALIB |-> calibrated_r)
        else $error("device accessed before calibration");

    cov_boot_done: cover property (st_r == ST_MRST ##1 st_r == ST_READY);
    cov_poll_again: cover property (st_r == ST_CAL_POLL && step && !acc.rdata[`DCL_CAL_READY]);
    cov_asleep: cover property (st_r == ST_GATE_SRC ##1 st_r == ST_ASLEEP);
    cov_wake_done: cover property (st_r == ST_CLR_LP && step);
endmodule : dcl_host_ctrl

// >>> verif/dcl_dev_model.sv
`timescale 1ns/10ps
module dcl_dev_model (
    input wire logic clk,
    input wire logic rst,
    input wire dcl_pkg::dcl_daddr_t dev_addr,
    input wire dcl_pkg::dcl_word_t dev_wdata,
    input wire logic dev_wr,
    input wire logic dev_rd,
    output dcl_pkg::dcl_word_t dev_rdata,
    input wire logic bus_clk_en,
    input wire logic src_clk_en,
    input wire logic calib_clk_en,
    input wire logic mod_rst
);
    import dcl_pkg::*;
    dcl_word_t cal_r;
    dcl_word_t refr_r;
    logic [3:0] cal_cnt;
    logic [2:0] stop_cnt;
    logic bus_q;
    logic src_q;
    logic [39:0] wlog [$];
    int faults = 0;
    logic cal_rdy;
    logic phy_rdy;
    assign cal_rdy = cal_cnt == 4'hf;
    assign phy_rdy = stop_cnt != 3'h7;
    always @(posedge clk) begin
        bus_q <= bus_clk_en;
        src_q <= src_clk_en;
        // released read bus keeps changing
        dev_rdata <= ~dev_rdata;
        if (rst) begin
            cal_r <= 32'h0;
            refr_r <= 32'h0;
            cal_cnt <= 4'h0;
            stop_cnt <= 3'h0;
            dev_rdata <= 32'h0;
        end else begin
            if (!cal_r[0]) cal_cnt <= 4'h0;
            else if (!cal_r[1] && !cal_rdy) cal_cnt <= cal_cnt + 4'h1;
            if (!refr_r[23]) stop_cnt <= 3'h0;
            else if (refr_r[31] && !refr_r[30] && phy_rdy) begin
                stop_cnt <= stop_cnt + 3'h1;
            end
            if (dev_wr) begin
                wlog.push_back({dev_addr, dev_wdata});
                if (dev_addr == 8'h00) cal_r <= dev_wdata;
                if (dev_addr == 8'h0c) refr_r <= dev_wdata;
            end
            if (dev_rd) begin
                case (dev_addr)
                    8'h00: dev_rdata <= {cal_r[31:5], cal_rdy, cal_r[3:0]};
                    8'h0c: dev_rdata <= refr_r;
                    8'h10: dev_rdata <= {29'h0, phy_rdy, 2'h0};
                    default: dev_rdata <= 32'h0;
                endcase
            end
            if ((dev_wr || dev_rd) && dev_addr != 8'h00 && !cal_rdy) faults <= faults + 1;
            if (mod_rst && !calib_clk_en) faults <= faults + 1;
            if (bus_q && !bus_clk_en && refr_r[31] && phy_rdy) faults <= faults + 1;
            if (src_q && !src_clk_en && (bus_clk_en || !refr_r[31] || refr_r[30])) begin
                faults <= faults + 1;
            end
        end
    end
endmodule : dcl_dev_model

// >>> verif/dcl_host_ctrl_tb.sv
`timescale 1ns/10ps
module dcl_host_ctrl_tb;
    import dcl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ref_clk = 1'b0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    dcl_saddr_t sw_addr = 4'h0;
    dcl_word_t sw_wdata = 32'h0;
    dcl_word_t sw_rdata;
    dcl_word_t dev_wdata;
    dcl_word_t dev_rdata;
    dcl_word_t rd;
    dcl_daddr_t dev_addr;
    logic dev_wr;
    logic dev_rd;
    logic [3:0] clks;
    int errors = 0;
    int n_compared = 0;
    int rst_cyc = 0;
    logic [39:0] exp_w [10] = '{40'h00_00000000, 40'h00_00000001, 40'h00_00000003,
        40'h00_0000000f, 40'h04_000000c5, 40'h08_00000033, 40'h0c_8000040e,
        40'h0c_8080040e, 40'h0c_8000040e, 40'h0c_0000040e};
    always #2.5 clk = ~clk;
    initial begin
        #37;
        forever #62.5 ref_clk = ~ref_clk;
    end
    always @(posedge clk) if (clks[0] === 1'b1 && clks[1] === 1'b1) rst_cyc++;
    dcl_host_ctrl #(.SETTLE_CYC(16'h4), .RST_HOLD_CYC(16'h2)) i_dcl_host_ctrl (
        .clk(clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ref_clk(ref_clk), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
        .bus_clk_en(clks[3]), .src_clk_en(clks[2]), .calib_clk_en(clks[1]), .mod_rst(clks[0]));
    dcl_dev_model i_dcl_dev_model (
        .clk(clk), .rst(rst), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
        .dev_rd(dev_rd), .dev_rdata(dev_rdata), .bus_clk_en(clks[3]), .src_clk_en(clks[2]),
        .calib_clk_en(clks[1]), .mod_rst(clks[0]));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic sw_write(input dcl_saddr_t a, input dcl_word_t d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input dcl_saddr_t a, output dcl_word_t d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : sw_read
    task automatic wait_state(input logic [4:0] code);
        for (int i = 0; i < 400; i++) begin
            sw_read(4'h8, rd);
            if (rd[12:8] === code) break;
        end
        check(rd[12:8], code);
    endtask : wait_state
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        sw_write(4'h0, 32'h2);
        sw_read(4'h8, rd);
        check(rd, 32'h0);
        sw_write(4'h4, 32'h07f5040e);
        sw_write(4'h0, 32'h1);
        sw_read(4'h8, rd);
        check(rd[12:0], 13'h0010);
        check(i_dcl_dev_model.wlog.size(), 0);
        sw_write(4'h4, 32'h0335040e);
        sw_read(4'h4, rd);
        check(rd, 32'h0335040e);
        sw_read(4'hc, rd);
        check(rd, 32'h0);
        sw_write(4'h0, 32'h1);
        wait_state(5'h0e);
        check(rd[2:1], 2'h3);
        check(rst_cyc, 2);
        check(clks, 4'he);
        sw_write(4'h0, 32'h2);
        wait_state(5'h19);
        check(clks, 4'h0);
        sw_write(4'h0, 32'h4);
        wait_state(5'h0e);
        check(clks, 4'he);
        check(i_dcl_dev_model.wlog.size(), 10);
        for (int i = 0; i < 10; i++) check(i_dcl_dev_model.wlog[i], exp_w[i]);
        sw_write(4'h4, 32'h1335040e);
        sw_write(4'h0, 32'h2);
        wait_state(5'h19);
        check(clks, 4'h6);
        sw_read(4'h4, rd);
        check(rd, 32'h1335040e);
        @(posedge clk);
        #1 check(sw_rdata, 32'h0);
        sw_write(4'h0, 32'h4);
        wait_state(5'h0e);
        check(clks, 4'he);
        check(i_dcl_dev_model.wlog.size(), 14);
        check(i_dcl_dev_model.faults, 0);
        stop_test;
    end
endmodule : dcl_host_ctrl_tb
